// file: core/fawwd_core.sv
// Fault action selection, window watchdog and diagnostic limit compare
//
// Function
// - Action codes: 0 none, 1 clear, 2 alarm voltage, 3 high impedance.
// - Self-diagnostic fault uses action bits 15-14, reset value 2.
// - Temperature outside limits uses action bits 13-12, reset 0.
// - Second input outside limits uses action bits 11-10, reset 0.
// - First input outside limits uses action bits 9-8, reset 0.
// - CRC or watchdog error share action bits 7-6, reset 0.
// - Reference fault uses action bits 5-4, reset value 2.
// - Overheat error above 130 C uses action bits 3-2, reset 0.
// - Overheat warning above 85 C uses action bits 1-0, reset 0.
// - Watchdog counts 1200 Hz ticks.
// - Enabled watchdog errors past upper limit; eight choices, reset code 3.
// - Lower limit code: 0 off, 64, 128, 512 ticks.
// - With lower limit on, only watchdog register writes restart the count.
// - With lower limit on, service outside window raises watchdog error.
// - With lower limit off, any register write restarts the count.
// - Window register bit 0 enables the watchdog, reset disabled.
// - High limit is field with four ones appended; greater result faults.
// - Low limit is field with four zeros appended; smaller result faults.
// - Link mode bit 0: 0 SPI, 1 break mode.
// - Link mode register written only through break link.
// - Polarity is register bit OR pin while pin enable is low.
// - Masked fault triggers no action; status still set.
`include "fawwd_cfg.svh"

module fawwd_core #(
	parameter int TICK_DIV = `FAWWD_TICK_DIV
) (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire fawwd_pkg::fawwd_wr_t   wrReq,
	input  wire logic [6:0]             rdAddr,
	input  wire fawwd_pkg::fawwd_faults_t faultIn,
	input  wire fawwd_pkg::fawwd_faults_t faultMask,
	input  wire logic                   wdMask,
	input  wire logic [2:0]             limMask,
	input  wire logic [11:0]            in0Result,
	input  wire logic [11:0]            in1Result,
	input  wire logic [11:0]            tempResult,
	input  wire logic                   resultValid,
	input  wire logic                   alarmLevelPolarity,
	input  wire logic                   secondInputPinEnable,
	input  wire logic                   polarityOrInputPin,
	output logic [15:0]                 rdData,
	output fawwd_pkg::fawwd_out_t       outMode,
	output logic                        alarmLevel,
	output logic                        breakLinkMode,
	output logic                        wdError,
	output logic [2:0]                  limFault
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fawwd_pkg::fawwd_state_t st_ff;
	fawwd_pkg::fawwd_state_t nxt_st;

	// Upper limit ticks per code
	function automatic logic [12:0] upTicks(input logic [2:0] code);
		case (code)
			3'h0: upTicks = 13'd64;
			3'h1: upTicks = 13'd128;
			3'h2: upTicks = 13'd512;
			3'h3: upTicks = 13'd1024;
			3'h4: upTicks = 13'd2048;
			3'h5: upTicks = 13'd3072;
			3'h6: upTicks = 13'd4096;
			default: upTicks = 13'd6144;
		endcase
	endfunction : upTicks

	// Lower limit ticks per code, zero when disabled
	function automatic logic [12:0] loTicks(input logic [1:0] code);
		case (code)
			2'h1: loTicks = 13'd64;
			2'h2: loTicks = 13'd128;
			2'h3: loTicks = 13'd512;
			default: loTicks = 13'd0;
		endcase
	endfunction : loTicks

	// Out-of-range compare with extended 12-bit limits
	function automatic logic outside(input logic [11:0] res, input fawwd_pkg::fawwd_limit_t lim);
		outside = (res > {lim.hiLimit, `FAWWD_HI_FILL})
			|| (res < {lim.loLimit, `FAWWD_LO_FILL});
	endfunction : outside

	// Map a fault action code onto the output mode
	function automatic fawwd_pkg::fawwd_out_t mapAct(input logic [1:0] act);
		case (act)
			`FAWWD_ACT_CLEAR: mapAct = fawwd_pkg::FAWWD_OUT_CLEAR;
			`FAWWD_ACT_ALARM: mapAct = fawwd_pkg::FAWWD_OUT_ALARM;
			`FAWWD_ACT_HIZ:   mapAct = fawwd_pkg::FAWWD_OUT_HIZ;
			default:          mapAct = fawwd_pkg::FAWWD_OUT_NORMAL;
		endcase
	endfunction : mapAct

	// Strongest action wins: hi-Z over alarm over clear over none
	function automatic logic [1:0] worst(input logic [1:0] a, input logic [1:0] b);
		worst = (a > b) ? a : b;
	endfunction : worst

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic        tick;
	logic        anyWrite;
	logic        winWrite;
	logic        serviced;
	logic [12:0] upLim;
	logic [12:0] loLim;
	logic        loOn;
	logic [2:0]  limNow;
	logic [1:0]  act;

	// Combinational next state; a write this cycle is seen next cycle
	always_comb begin
		nxt_st = st_ff;
		tick = (st_ff.divCnt == 14'(TICK_DIV - 1));
		nxt_st.divCnt = tick ? 14'h0000 : st_ff.divCnt + 14'h0001;
		anyWrite = wrReq.valid;
		winWrite = wrReq.valid && (wrReq.addr == `FAWWD_OFS_WINDOW);
		upLim = upTicks(st_ff.window.window_upper_limit);
		loLim = loTicks(st_ff.window.window_lower_limit);
		loOn = (st_ff.window.window_lower_limit != 2'h0);
		// Restart source depends on whether the window is armed
		serviced = loOn ? winWrite : anyWrite;
		limNow = 3'h0;
		act = `FAWWD_ACT_NONE;

		// Register writes
		if (wrReq.valid) begin
			if (wrReq.addr == `FAWWD_OFS_ACTION) begin
				nxt_st.action = wrReq.data;
			end else if (wrReq.addr == `FAWWD_OFS_WINDOW) begin
				nxt_st.window = {{`FAWWD_WIN_UNUSED{1'b0}}, wrReq.data[5:0]};
			end else if (wrReq.addr == `FAWWD_OFS_IN0LIM) begin
				nxt_st.in0Lim = wrReq.data;
			end else if (wrReq.addr == `FAWWD_OFS_IN1LIM) begin
				nxt_st.in1Lim = wrReq.data;
			end else if (wrReq.addr == `FAWWD_OFS_TEMPLIM) begin
				nxt_st.tempLim = wrReq.data;
			end else if (wrReq.addr == `FAWWD_OFS_LINKMODE && wrReq.viaBreak) begin
				nxt_st.breakLinkMode = wrReq.data[0];
			end
		end

		// Window watchdog; error is sticky until the timer is disabled
		if (!st_ff.window.window_timer_enable) begin
			nxt_st.winCnt = 13'h0000;
			nxt_st.wdError = 1'b0;
		end else begin
			if (serviced) begin
				nxt_st.winCnt = 13'h0000;
				if (loOn && (st_ff.winCnt < loLim || st_ff.winCnt > upLim)) begin
					nxt_st.wdError = 1'b1;
				end
			end else if (tick && st_ff.winCnt <= upLim) begin
				nxt_st.winCnt = st_ff.winCnt + 13'h0001;
			end
			if (!serviced && st_ff.winCnt > upLim) begin
				nxt_st.wdError = 1'b1;
			end
		end

		// Limit compare on each new converter result
		limNow[0] = outside(in0Result, st_ff.in0Lim);
		limNow[1] = outside(in1Result, st_ff.in1Lim);
		limNow[2] = outside(tempResult, st_ff.tempLim);
		if (resultValid) begin
			nxt_st.limFault = limNow;
		end

		// Combine unmasked faults; action lasts while fault stands
		if (faultIn.selfcheck && !faultMask.selfcheck) begin
			act = worst(act, st_ff.action.selfcheck_fault_action);
		end
		if (st_ff.limFault[2] && !limMask[2]) begin
			act = worst(act, st_ff.action.temperature_limit_action);
		end
		if (st_ff.limFault[1] && !limMask[1]) begin
			act = worst(act, st_ff.action.input1_limit_action);
		end
		if (st_ff.limFault[0] && !limMask[0]) begin
			act = worst(act, st_ff.action.input0_limit_action);
		end
		if ((faultIn.crcError && !faultMask.crcError) || (st_ff.wdError && !wdMask)) begin
			act = worst(act, st_ff.action.link_error_action);
		end
		if (faultIn.reference && !faultMask.reference) begin
			act = worst(act, st_ff.action.reference_fault_action);
		end
		if (faultIn.overheatError && !faultMask.overheatError) begin
			act = worst(act, st_ff.action.overheat_error_action);
		end
		if (faultIn.overheatWarning && !faultMask.overheatWarning) begin
			act = worst(act, st_ff.action.overheat_warning_action);
		end
		nxt_st.outMode = mapAct(act);
		nxt_st.alarmLevel = alarmLevelPolarity
			|| (polarityOrInputPin && !secondInputPinEnable);

		// Read mux; unmapped offsets read zero
		if (rdAddr == `FAWWD_OFS_ACTION) begin
			nxt_st.rdData = st_ff.action;
		end else if (rdAddr == `FAWWD_OFS_WINDOW) begin
			nxt_st.rdData = st_ff.window;
		end else if (rdAddr == `FAWWD_OFS_IN0LIM) begin
			nxt_st.rdData = st_ff.in0Lim;
		end else if (rdAddr == `FAWWD_OFS_IN1LIM) begin
			nxt_st.rdData = st_ff.in1Lim;
		end else if (rdAddr == `FAWWD_OFS_TEMPLIM) begin
			nxt_st.rdData = st_ff.tempLim;
		end else if (rdAddr == `FAWWD_OFS_LINKMODE) begin
			nxt_st.rdData = {15'h0000, st_ff.breakLinkMode};
		end else begin
			nxt_st.rdData = 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
			st_ff.action <= `FAWWD_RST_ACTION;
			st_ff.window <= `FAWWD_RST_WINDOW;
			st_ff.in0Lim <= `FAWWD_RST_LIMIT;
			st_ff.in1Lim <= `FAWWD_RST_LIMIT;
			st_ff.tempLim <= `FAWWD_RST_LIMIT;
			st_ff.breakLinkMode <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flops
	assign rdData        = st_ff.rdData;
	assign outMode       = st_ff.outMode;
	assign alarmLevel    = st_ff.alarmLevel;
	assign breakLinkMode = st_ff.breakLinkMode;
	assign wdError       = st_ff.wdError;
	assign limFault      = st_ff.limFault;

endmodule : fawwd_core

// file: core/fawwd_cfg.svh
// Offsets, field positions, reset values and timing constants of the fault and watchdog block
`ifndef FAWWD_CFG_SVH
`define FAWWD_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FAWWD_OFS_ACTION   7'h10
`define FAWWD_OFS_WINDOW   7'h11
`define FAWWD_OFS_IN0LIM   7'h12
`define FAWWD_OFS_IN1LIM   7'h13
`define FAWWD_OFS_TEMPLIM  7'h14
`define FAWWD_OFS_LINKMODE 7'h16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FAWWD_RST_ACTION   16'h8020
`define FAWWD_RST_WINDOW   16'h0018
`define FAWWD_RST_LIMIT    16'hFF00
`define FAWWD_RST_LINKMODE 16'h0000

// ----------------------------------------------------------------
// Fault action encodings
// ----------------------------------------------------------------
`define FAWWD_ACT_NONE  2'h0
`define FAWWD_ACT_CLEAR 2'h1
`define FAWWD_ACT_ALARM 2'h2
`define FAWWD_ACT_HIZ   2'h3

// ----------------------------------------------------------------
// Field widths of the window register
// ----------------------------------------------------------------
`define FAWWD_WIN_UNUSED 10

// ----------------------------------------------------------------
// Limit extension patterns
// ----------------------------------------------------------------
`define FAWWD_HI_FILL 4'hF
`define FAWWD_LO_FILL 4'h0

// ----------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------
`define FAWWD_CLK_HZ    10000000
`define FAWWD_TICK_HZ   1200
`define FAWWD_TICK_DIV  (`FAWWD_CLK_HZ / `FAWWD_TICK_HZ)
`define FAWWD_CNT_W     13

`endif

// file: core/fawwd_pkg.sv
// Types shared by the fault action and window watchdog block
package fawwd_pkg;

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] selfcheck_fault_action;
		logic [1:0] temperature_limit_action;
		logic [1:0] input1_limit_action;
		logic [1:0] input0_limit_action;
		logic [1:0] link_error_action;
		logic [1:0] reference_fault_action;
		logic [1:0] overheat_error_action;
		logic [1:0] overheat_warning_action;
	} fawwd_action_t;

	typedef struct packed {
		logic [9:0] unused;
		logic [2:0] window_upper_limit;
		logic [1:0] window_lower_limit;
		logic       window_timer_enable;
	} fawwd_window_t;

	typedef struct packed {
		logic [7:0] hiLimit;
		logic [7:0] loLimit;
	} fawwd_limit_t;

	// Register write request from the serial front end
	typedef struct packed {
		logic        valid;
		logic        viaBreak;
		logic [6:0]  addr;
		logic [15:0] data;
	} fawwd_wr_t;

	// Fault sources, one bit each
	typedef struct packed {
		logic selfcheck;
		logic reference;
		logic overheatError;
		logic overheatWarning;
		logic crcError;
	} fawwd_faults_t;

	typedef enum logic [1:0] {
		FAWWD_OUT_NORMAL = 2'b00,
		FAWWD_OUT_CLEAR  = 2'b01,
		FAWWD_OUT_ALARM  = 2'b10,
		FAWWD_OUT_HIZ    = 2'b11
	} fawwd_out_t;

	// Whole module state
	typedef struct packed {
		fawwd_action_t action;
		fawwd_window_t window;
		fawwd_limit_t  in0Lim;
		fawwd_limit_t  in1Lim;
		fawwd_limit_t  tempLim;
		logic          breakLinkMode;
		logic [13:0]   divCnt;
		logic [12:0]   winCnt;
		logic          wdError;
		logic [2:0]    limFault;
		fawwd_out_t    outMode;
		logic          alarmLevel;
		logic [15:0]   rdData;
	} fawwd_state_t;

endpackage : fawwd_pkg

// file: dv/fawwd_host_model.sv
// Host controller model issuing register writes over either link
module fawwd_host_model (
	input  wire logic            clk,
	output fawwd_pkg::fawwd_wr_t wrReq
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus carries inverted junk so stale fields never pass for a request
	initial wrReq = '{1'b0, 1'b1, 7'h7F, 16'hFFFF};
	// One write per call, held for exactly one sampling edge
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic brk);
		@(posedge clk);
		#1 wrReq = '{1'b1, brk, a, d};
		@(posedge clk);
		#1 wrReq = '{1'b0, ~brk, ~a, ~d};
	endtask : wr
	// Service the watchdog through its own register after a chosen delay
	task automatic service(input int n, input logic [15:0] d);
		repeat (n) @(posedge clk);
		wr(7'h11, d, 1'b0);
	endtask : service
endmodule : fawwd_host_model

// file: dv/fawwd_core_properties.sv
// Port-level properties of the fault action and window watchdog block
`include "fawwd_cfg.svh"
module fawwd_core_properties (
	input wire logic                     clk,
	input wire logic                     rst_b,
	input wire fawwd_pkg::fawwd_wr_t     wrReq,
	input wire logic [6:0]               rdAddr,
	input wire fawwd_pkg::fawwd_faults_t faultIn,
	input wire fawwd_pkg::fawwd_faults_t faultMask,
	input wire logic                     wdMask,
	input wire logic [2:0]               limMask,
	input wire logic                     resultValid,
	input wire logic                     alarmLevelPolarity,
	input wire logic                     secondInputPinEnable,
	input wire logic                     polarityOrInputPin,
	input wire logic [15:0]              rdData,
	input wire fawwd_pkg::fawwd_out_t    outMode,
	input wire logic                     alarmLevel,
	input wire logic                     breakLinkMode,
	input wire logic                     wdError,
	input wire logic [2:0]               limFault
);
	// Decoded write kinds and the no-unmasked-fault condition
	wire linkWr = wrReq.valid && wrReq.addr == `FAWWD_OFS_LINKMODE;
	wire wdOff = wrReq.valid && wrReq.addr == `FAWWD_OFS_WINDOW && !wrReq.data[0];
	wire quiet = (faultIn & ~faultMask) == 5'h00 && !(wdError && !wdMask)
		&& (limFault & ~limMask) == 3'h0;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Three quiet cycles cover the two-stage limit path plus action latency
	sequence quietRun_s;
		quiet [*3];
	endsequence
	sequence noSample_s;
		!resultValid [*3];
	endsequence
	a_link_spi_refused: assert property (linkWr && !wrReq.viaBreak |=> $stable(breakLinkMode))
		else $error("link mode changed by a write over spi");
	a_link_break_taken: assert property (linkWr && wrReq.viaBreak |=> breakLinkMode == $past(wrReq.data[0]))
		else $error("link mode not taken from break write");
	a_link_read_back: assert property (rdAddr == `FAWWD_OFS_LINKMODE |=> rdData == {15'h0000, $past(breakLinkMode)})
		else $error("link mode read back wrong");
	a_polarity_merge: assert property (1'b1 |=> alarmLevel == $past(alarmLevelPolarity | (polarityOrInputPin & ~secondInputPinEnable)))
		else $error("alarm level not the merged polarity");
	a_quiet_normal: assert property (quietRun_s |=> outMode == fawwd_pkg::FAWWD_OUT_NORMAL)
		else $error("output action without an unmasked fault");
	a_limit_stable: assert property (noSample_s |=> $stable(limFault))
		else $error("limit flags moved without a new result");
	a_wd_sticky: assert property (wdError && !wdOff && !$past(wdOff) |=> wdError)
		else $error("watchdog error dropped while enabled");
	a_wd_disable_clears: assert property (wdOff |=> ##1 !wdError)
		else $error("watchdog error kept after disable");
endmodule : fawwd_core_properties

bind fawwd_core fawwd_core_properties chk_u (.clk, .rst_b, .wrReq, .rdAddr, .faultIn,
	.faultMask, .wdMask, .limMask, .resultValid, .alarmLevelPolarity, .secondInputPinEnable,
	.polarityOrInputPin, .rdData, .outMode, .alarmLevel, .breakLinkMode, .wdError, .limFault);

// file: dv/fawwd_core_tb.sv
// Self-checking bench for the fault action and window watchdog block
module fawwd_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, wdMask, resultValid, alarmLevel, breakLinkMode, wdError;
	logic alarmLevelPolarity, secondInputPinEnable, polarityOrInputPin;
	logic [6:0] rdAddr;
	logic [2:0] limMask, limFault;
	logic [11:0] res;
	logic [15:0] rdData;
	fawwd_pkg::fawwd_wr_t wrReq;
	fawwd_pkg::fawwd_faults_t faultIn, faultMask;
	fawwd_pkg::fawwd_out_t outMode;
	int errors = 0, compares = 0, cycles = 0;
	// Short tick divider keeps watchdog windows to a few hundred cycles
	fawwd_core #(.TICK_DIV(4)) dut_u (.clk, .rst_b, .wrReq, .rdAddr, .faultIn, .faultMask,
		.wdMask, .limMask, .in0Result(res), .in1Result(res), .tempResult(res), .resultValid,
		.alarmLevelPolarity, .secondInputPinEnable, .polarityOrInputPin, .rdData, .outMode,
		.alarmLevel, .breakLinkMode, .wdError, .limFault);
	fawwd_host_model host_u (.clk, .wrReq);
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		rdAddr = a;
		cyc(1);
		d = rdData;
	endtask : rd
	task automatic t_regs;
		logic [6:0] adr [7] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h16, 7'h15};
		logic [15:0] rv [7] = '{16'h8020, 16'h0018, 16'hFF00, 16'hFF00, 16'hFF00, 16'h0, 16'h0};
		logic [15:0] d;
		for (int i = 0; i < 7; i++) begin
			rd(adr[i], d);
			chk("reset value", rv[i], d);
		end
		host_u.wr(7'h15, 16'hABCD, 1'b0);
		rd(7'h15, d);
		chk("unmapped read", 16'h0000, d);
		host_u.wr(7'h11, 16'hFFC6, 1'b0);
		rd(7'h11, d);
		chk("window fields", 16'h0006, d);
	endtask : t_regs
	task automatic t_faults;
		int sh [5] = '{6, 0, 2, 4, 14};
		for (int k = 0; k < 5; k++) begin
			for (int c = 1; c < 4; c++) begin
				host_u.wr(7'h10, 16'(c << sh[k]), 1'b0);
				faultIn = 5'(1 << k);
				cyc(3);
				chk("fault action", 16'(c), 16'(outMode));
				cyc(8);
				chk("held action", 16'(c), 16'(outMode));
				faultMask = faultIn;
				cyc(3);
				chk("masked action", 16'h0000, 16'(outMode));
				faultIn = '0;
				faultMask = '0;
			end
		end
	endtask : t_faults
	task automatic t_limits;
		logic [11:0] v [4] = '{12'h80F, 12'h810, 12'h100, 12'h0FF};
		for (int a = 18; a < 21; a++)
			host_u.wr(7'(a), 16'h8010, 1'b0);
		for (int i = 0; i < 4; i++) begin
			res = v[i];
			resultValid = 1'b1;
			cyc(1);
			resultValid = 1'b0;
			cyc(3);
			chk("limit flags", 16'({3{i[0]}}), 16'(limFault));
		end
		for (int ch = 0; ch < 3; ch++) begin
			host_u.wr(7'h10, 16'(3 << (8 + 2 * ch)), 1'b0);
			limMask = ~3'(1 << ch);
			cyc(3);
			chk("limit action", 16'h0003, 16'(outMode));
		end
		limMask = 3'h7;
	endtask : t_limits
	task automatic t_link_pins;
		logic [15:0] d;
		host_u.wr(7'h16, 16'h0001, 1'b0);
		chk("link mode over spi", 16'h0000, 16'(breakLinkMode));
		host_u.wr(7'h16, 16'h0001, 1'b1);
		chk("link mode over break", 16'h0001, 16'(breakLinkMode));
		rd(7'h16, d);
		chk("link mode read", 16'h0001, d);
		for (int i = 0; i < 8; i++) begin
			{alarmLevelPolarity, secondInputPinEnable, polarityOrInputPin} = 3'(i);
			cyc(1);
			chk("alarm level", 16'(i[2] | (i[0] & ~i[1])), 16'(alarmLevel));
		end
	endtask : t_link_pins
	task automatic t_watchdog;
		wdMask = 1'b0;
		host_u.wr(7'h11, 16'h0001, 1'b0);
		cyc(240);
		chk("watchdog early", 16'h0000, 16'(wdError));
		host_u.wr(7'h10, 16'h00C0, 1'b0);
		cyc(240);
		chk("watchdog restarted", 16'h0000, 16'(wdError));
		cyc(40);
		chk("watchdog expired", 16'h0001, 16'(wdError));
		chk("link error action", 16'h0003, 16'(outMode));
		host_u.wr(7'h11, 16'h0000, 1'b0);
		// Disable lands in the register first, the error drops one edge later
		cyc(1);
		chk("watchdog cleared", 16'h0000, 16'(wdError));
		host_u.wr(7'h11, 16'h000B, 1'b0);
		host_u.service(100, 16'h000B);
		cyc(1);
		chk("early service", 16'h0001, 16'(wdError));
		host_u.wr(7'h11, 16'h0000, 1'b0);
		host_u.wr(7'h11, 16'h000B, 1'b0);
		cyc(150);
		host_u.wr(7'h12, 16'h8010, 1'b0);
		host_u.service(150, 16'h000B);
		cyc(1);
		chk("in window service", 16'h0000, 16'(wdError));
		cyc(560);
		chk("window expired", 16'h0001, 16'(wdError));
	endtask : t_watchdog
	task automatic report_and_stop;
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	// Main sequence: quiet inputs through reset, then each scenario in turn
	initial begin
		rst_b = 1'b0;
		{wdMask, resultValid, limMask} = 5'h17;
		{alarmLevelPolarity, secondInputPinEnable, polarityOrInputPin} = 3'h0;
		res = 12'h000;
		rdAddr = 7'h00;
		faultIn = '0;
		faultMask = '0;
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		t_regs();
		t_faults();
		t_limits();
		t_link_pins();
		t_watchdog();
		report_and_stop();
	end
endmodule : fawwd_core_tb
